// ===== pkg/comb_filter_regs.svh
// register offsets, field positions, reset values and timing counts of the comb filter
`ifndef COMB_FILTER_REGS_SVH
`define COMB_FILTER_REGS_SVH

// ****************************************************************
// bus addressing
// ****************************************************************
`define I2C_DEV_ADDR 7'h59
`define CTRL_SUBADDR 8'h00
`define CTRL_RESET 8'h00
`define READ_FILL 8'h00

// ****************************************************************
// control byte field positions
// ****************************************************************
`define BIT_BYPASS 7
`define BIT_INPUT_MODE 6
`define BIT_CHROMA_COMB 5
`define BIT_SUBTRACT 4
`define BIT_TAP_SEL 3
`define BIT_FREQ_SEL 2
`define BIT_LINE_COUNT 1
`define BIT_LINE_LENGTH 0

// ****************************************************************
// timing counts in system clock cycles, and the chroma output offset
// ****************************************************************
`define FILT_LAT 21
`define BYP_LAT 3
`define LINE_625 11'd1728
`define LINE_525 11'd1716
`define BP_SPAN_443 4'h3
`define BP_SPAN_358 4'h4
`define CHROMA_OFFSET 12'sh080

`endif

// ===== pkg/comb_filter_pkg.sv
// types shared by the comb filter modules
package comb_filter_pkg;

  // field order follows the control byte from bit 7 down to bit 0
  typedef struct packed {
    logic bypassSelect;
    logic inputModeSelect;
    logic chromaCombSelect;
    logic lumaChromaSubtract;
    logic adderTapSelect;
    logic subcarrierFreqSelect;
    logic lineCountSelect;
    logic lineLengthSelect;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } yc_t;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_SUB,
    ST_ACK_SUB,
    ST_DATA,
    ST_ACK_DATA,
    ST_READ,
    ST_READ_ACK,
    ST_READ_NEXT
  } i2c_state_t;

endpackage

// ===== core/line_delay.sv
// one video line delay built as a ring buffer of programmable length
`timescale 1ns/100ps
module line_delay #(
  parameter int DW = 8,
  parameter int MAX_LEN = 1728
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [10:0] len,
  input wire logic [DW-1:0] din,
  output logic [DW-1:0] dout
);

  if (MAX_LEN > 2047 || MAX_LEN < 2) begin : g_chk
    $error("line_delay: MAX_LEN out of range");
  end

  logic [DW-1:0] mem [MAX_LEN];
  logic [10:0] ptr;
  logic [10:0] next_ptr;

  // the slot read back is the one written exactly len enabled cycles ago
  always_comb begin
    next_ptr = ptr;
    if (en) begin
      next_ptr = (ptr >= len - 11'd1) ? 11'd0 : ptr + 11'd1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr <= 11'd0;
      dout <= '0;
    end else begin
      ptr <= next_ptr;
      if (en) begin
        dout <= mem[ptr];
      end
    end
  end

  // memory holds no reset: its contents are flushed by a line of video anyway
  always_ff @(posedge sys_clk) begin
    if (en) begin
      mem[ptr] <= din;
    end
  end

endmodule

// ===== core/video_comb_filter.sv
// line-locked comb filter separating composite video into luma and chroma
`timescale 1ns/100ps
`include "comb_filter_regs.svh"

// Summary of operation
// - Filtered outputs appear exactly 21 clocks after their input sample.
// - Bypass passes inputs to outputs with exactly 3 clocks of latency.
// - Bit 7 set selects bypass and disables all other filtering.
// - Answer as I2C slave at address byte B2, then subaddress, then data.
// - With read bit set, transmit register data back to the master.
// - Acknowledge address, subaddress and every received data byte.
// - Subaddress increments after each data byte.
// - Control byte at subaddress 00, bits bypass down to line length.
// - Bit 6 picks composite input or separate luma and chroma inputs.
// - Bit 5 picks bandpass or comb filtered chroma output.
// - Bit 4 subtracts chroma from composite, else luma is low-passed only.
// - Bit 3 picks the tap fed to the adder: bandpass or comb.
// - Bit 2 sets chroma filter centre to 4.43 or 3.58 MHz.
// - Bit 1 picks three-line PAL or two-line NTSC combing.
// - Bit 0 sets line delay to 1728 or 1716 clocks.
// - Everything runs on the single line-locked system clock.
// - Luma and chroma output words are updated on every enabled clock.
module video_comb_filter #(
  parameter int DW = 8,
  parameter int MAX_LINE = 1728
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [7:0] compositeIn,
  input wire logic [7:0] chromaIn,
  output comb_filter_pkg::yc_t ycOut,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  import comb_filter_pkg::*;

  localparam int FILT_STAGES = `FILT_LAT - 6; // input, four adder_tap_select to centre, output regs
  localparam int ADDER_TAP_SELECT = 9;

  if (DW != 8 || MAX_LINE < 1728) begin : g_chk
    $error("video_comb_filter: unsupported DW or MAX_LINE");
  end

  // ****************************************************************
  // i2c slave
  // ****************************************************************
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic sclPrev;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  i2c_state_t state;
  i2c_state_t next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] subAddr;
  logic [7:0] next_subAddr;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic readMode;
  logic next_readMode;
  logic next_sdaOe;
  logic [7:0] readData;

  // only the second synchroniser stage and its delayed copy feed the detectors
  assign sclRise = sclSync[1] & ~sclPrev;
  assign sclFall = ~sclSync[1] & sclPrev;
  assign startCond = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
  assign stopCond = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];
  assign readData = (subAddr == `CTRL_SUBADDR) ? ctrl : `READ_FILL;

  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_shift = shift;
    next_subAddr = subAddr;
    next_ctrl = ctrl;
    next_readMode = readMode;
    next_sdaOe = sdaOe;
    if (startCond) begin
      next_state = ST_ADDR;
      next_bitCnt = 4'h0;
      next_sdaOe = 1'b0;
    end else if (stopCond) begin
      next_state = ST_IDLE;
      next_sdaOe = 1'b0;
    end else if (sclRise) begin
      case (state)
        ST_ADDR, ST_SUB, ST_DATA: begin
          next_shift = {shift[6:0], sdaSync[1]};
          next_bitCnt = bitCnt + 4'h1;
        end
        ST_READ: begin
          next_shift = {shift[6:0], 1'b0};
          next_bitCnt = bitCnt + 4'h1;
        end
        ST_READ_ACK: begin
          next_subAddr = subAddr + 8'h01;
          next_state = sdaSync[1] ? ST_IDLE : ST_READ_NEXT;
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      case (state)
        ST_ADDR: begin
          if (bitCnt == 4'h8) begin
            if (shift[7:1] == `I2C_DEV_ADDR) begin
              next_state = ST_ACK_ADDR;
              next_readMode = shift[0];
              next_sdaOe = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          next_bitCnt = 4'h0;
          if (readMode) begin
            next_state = ST_READ;
            next_shift = readData;
            next_sdaOe = ~readData[7];
          end else begin
            next_state = ST_SUB;
            next_sdaOe = 1'b0;
          end
        end
        ST_SUB: begin
          if (bitCnt == 4'h8) begin
            next_subAddr = shift;
            next_state = ST_ACK_SUB;
            next_sdaOe = 1'b1;
          end
        end
        ST_DATA: begin
          if (bitCnt == 4'h8) begin
            if (subAddr == `CTRL_SUBADDR) begin
              next_ctrl = shift;
            end
            next_state = ST_ACK_DATA;
            next_sdaOe = 1'b1;
          end
        end
        ST_ACK_SUB, ST_ACK_DATA: begin
          if (state == ST_ACK_DATA) begin
            next_subAddr = subAddr + 8'h01;
          end
          next_state = ST_DATA;
          next_bitCnt = 4'h0;
          next_sdaOe = 1'b0;
        end
        ST_READ: begin
          if (bitCnt == 4'h8) begin
            next_state = ST_READ_ACK;
            next_sdaOe = 1'b0;
          end else begin
            next_sdaOe = ~shift[7];
          end
        end
        ST_READ_NEXT: begin
          next_state = ST_READ;
          next_bitCnt = 4'h0;
          next_shift = readData;
          next_sdaOe = ~readData[7];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclSync <= 2'b11;
      sdaSync <= 2'b11;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shift <= 8'h00;
      subAddr <= 8'h00;
      ctrl <= `CTRL_RESET;
      readMode <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else if (clkEn) begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
      state <= next_state;
      bitCnt <= next_bitCnt;
      shift <= next_shift;
      subAddr <= next_subAddr;
      ctrl <= next_ctrl;
      readMode <= next_readMode;
      sdaOe <= next_sdaOe;
      sdaOut <= 1'b0;
    end
  end

  // ****************************************************************
  // control hand-over at line boundaries
  // ****************************************************************
  ctrl_t activeCtrl;
  ctrl_t next_activeCtrl;
  logic [10:0] lineLen;
  logic [10:0] lineCnt;
  logic [10:0] next_lineCnt;
  logic lineWrap;

  // switching mid-line would tear a line apart, so changes wait for its end
  assign lineLen = activeCtrl.lineLengthSelect ? `LINE_525 : `LINE_625;
  assign lineWrap = (lineCnt >= lineLen - 11'd1);

  always_comb begin
    next_lineCnt = lineWrap ? 11'd0 : lineCnt + 11'd1;
    next_activeCtrl = lineWrap ? ctrl_t'(ctrl) : activeCtrl;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lineCnt <= 11'd0;
      activeCtrl <= ctrl_t'(`CTRL_RESET);
    end else if (clkEn) begin
      lineCnt <= next_lineCnt;
      activeCtrl <= next_activeCtrl;
    end
  end

  // ****************************************************************
  // sample pipeline
  // ****************************************************************
  logic [7:0] compTap [ADDER_TAP_SELECT];
  logic [7:0] chTap [ADDER_TAP_SELECT];
  logic [7:0] srcTap [ADDER_TAP_SELECT];
  logic [7:0] lineD1;
  logic [7:0] lineD2;
  logic [3:0] span;
  logic signed [11:0] centre;
  logic signed [11:0] bandPass;
  logic signed [11:0] lowPass;
  logic signed [11:0] combC;
  logic signed [11:0] adderC;
  logic signed [11:0] lumaS;
  yc_t filtResult;
  yc_t filtPipe [FILT_STAGES];
  yc_t bypassStage;
  yc_t next_ycOut;

  function automatic logic [7:0] clampU(input logic signed [11:0] v);
    if (v < 12'sh000) begin
      return 8'h00;
    end
    return (v > 12'sh0FF) ? 8'hFF : v[7:0];
  endfunction

  line_delay #(.DW(8), .MAX_LEN(MAX_LINE)) u_line1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(clkEn),
    .len(lineLen),
    .din(compTap[4]),
    .dout(lineD1)
  );

  line_delay #(.DW(8), .MAX_LEN(MAX_LINE)) u_line2 (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(clkEn),
    .len(lineLen),
    .din(lineD1),
    .dout(lineD2)
  );

  always_comb begin
    for (int i = 0; i < ADDER_TAP_SELECT; i++) begin
      srcTap[i] = activeCtrl.inputModeSelect ? chTap[i] : compTap[i];
    end
    span = activeCtrl.subcarrierFreqSelect ? `BP_SPAN_358 : `BP_SPAN_443;
    centre = {4'h0, compTap[4]};
    // with bit 6 clear the three-tap sections share the centre tap so band-pass and trap stay complementary
    bandPass = (($signed({4'h0, srcTap[4]}) <<< 1) - $signed({4'h0, srcTap[4 - span]})
      - $signed({4'h0, srcTap[4 + span]})) >>> 2;
    lowPass = ((centre <<< 1) + $signed({4'h0, compTap[4 - span]})
      + $signed({4'h0, compTap[4 + span]})) >>> 2;
    // ntsc inverts subcarrier each line, pal only every second line
    combC = (centre - $signed({4'h0, (activeCtrl.lineCountSelect ? lineD1 : lineD2)}))
      >>> 1;
    adderC = activeCtrl.adderTapSelect ? combC : bandPass;
    lumaS = activeCtrl.lumaChromaSubtract ? centre - adderC : lowPass;
    filtResult.luma = clampU(lumaS);
    filtResult.chroma = clampU((activeCtrl.chromaCombSelect ? combC : bandPass)
      + `CHROMA_OFFSET);
    next_ycOut = activeCtrl.bypassSelect ? bypassStage : filtPipe[FILT_STAGES-1];
  end

  // every stage moves each enabled clock, so latency is fixed in clocks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ADDER_TAP_SELECT; i++) begin
        compTap[i] <= 8'h00;
        chTap[i] <= 8'h00;
      end
      for (int i = 0; i < FILT_STAGES; i++) begin
        filtPipe[i] <= '0;
      end
      bypassStage <= '0;
      ycOut <= '0;
    end else if (clkEn) begin
      compTap[0] <= compositeIn;
      chTap[0] <= chromaIn;
      for (int i = 1; i < ADDER_TAP_SELECT; i++) begin
        compTap[i] <= compTap[i-1];
        chTap[i] <= chTap[i-1];
      end
      filtPipe[0] <= filtResult;
      for (int i = 1; i < FILT_STAGES; i++) begin
        filtPipe[i] <= filtPipe[i-1];
      end
      bypassStage <= {compTap[0], chTap[0]};
      ycOut <= next_ycOut;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [4:0] enRun;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enRun <= 5'h00;
    end else begin
      enRun <= !clkEn ? 5'h00 : (enRun == 5'h1F ? enRun : enRun + 5'h01);
    end
  end

  a_bypass_latency: assert property (
    enRun >= 5'd4 && $past(activeCtrl.bypassSelect) && $past(activeCtrl.bypassSelect, 2)
    |-> ycOut == {$past(compositeIn, 3), $past(chromaIn, 3)})
    else $error("bypass output is not the input of three clocks before");
  a_filter_latency: assert property (
    enRun >= 5'd22 && !$past(activeCtrl.bypassSelect) |-> ycOut == $past(filtResult, 16))
    else $error("filtered output does not follow its sample by 21 clocks");
  a_addr_ack: assert property (
    clkEn && !startCond && !stopCond && sclFall && state == ST_ADDR && bitCnt == 4'h8
    && shift[7:1] == `I2C_DEV_ADDR |=> sdaOe && state == ST_ACK_ADDR)
    else $error("own address was not acknowledged");
  a_addr_ignore: assert property (
    clkEn && !startCond && !stopCond && sclFall && state == ST_ADDR && bitCnt == 4'h8
    && shift[7:1] != `I2C_DEV_ADDR |=> !sdaOe && state == ST_IDLE)
    else $error("foreign address was answered");
  a_data_store: assert property (
    clkEn && !startCond && !stopCond && sclFall && state == ST_DATA && bitCnt == 4'h8
    && subAddr == `CTRL_SUBADDR |=> ctrl == $past(shift) && sdaOe)
    else $error("control byte not stored and acknowledged");
  a_sub_increment: assert property (
    clkEn && !startCond && !stopCond && sclFall && state == ST_ACK_DATA
    |=> subAddr == $past(subAddr) + 8'h01 && state == ST_DATA)
    else $error("subaddress did not advance after a data byte");
  a_read_drive: assert property (
    clkEn && !startCond && !stopCond && sclFall && state == ST_READ && bitCnt != 4'h8
    |=> sdaOe == !$past(shift[7]))
    else $error("read bit not driven from the shift register");
  a_ctrl_apply: assert property (
    clkEn && lineWrap |=> activeCtrl == ctrl_t'($past(ctrl)) ##1 !lineWrap)
    else $error("control byte not applied at line end");
  a_ctrl_hold: assert property (
    clkEn && !lineWrap |=> $stable(activeCtrl))
    else $error("active control changed inside a line");
  a_line_length: assert property (
    clkEn && $past(clkEn) && lineWrap
    |-> lineCnt == lineLen - 11'd1 && $past(lineCnt) == lineLen - 11'd2)
    else $error("line length count is wrong");

  c_bypass_run: cover property (enRun >= 5'd4 && activeCtrl.bypassSelect);
  c_ctrl_write: cover property (state == ST_ACK_DATA && subAddr == `CTRL_SUBADDR);
  c_read_byte: cover property (state == ST_READ_ACK);
  c_comb_ntsc: cover property (lineWrap && activeCtrl.lineCountSelect);

endmodule

// ===== tb/i2c_master_model.sv
// open-drain register-bus master that talks to the comb filter's slave port
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic sys_clk,
  input wire logic sdaOe,
  output logic scl,
  output logic sdaLine
);
  logic sdaDrv;

  // ****************************************************************
  // wire resolution
  // ****************************************************************
  // pulled-up line: low while either party pulls it, high once both release
  assign sdaLine = sdaDrv & ~sdaOe;

  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // ****************************************************************
  // bit and byte framing
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic start();
    sdaDrv = 1'b1;
    scl = 1'b1;
    tick(10);
    sdaDrv = 1'b0;
    tick(10);
    scl = 1'b0;
    tick(5);
  endtask

  // data moves mid-low, far from both edges, and is read late in the high phase, one clock before scl falls
  task automatic bitIo(input logic b, output logic r);
    sdaDrv = b;
    tick(5);
    scl = 1'b1;
    tick(9);
    r = sdaLine;
    tick(1);
    scl = 1'b0;
    tick(5);
  endtask

  // msb first; the ninth bit is released so the slave can acknowledge
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(b[i], r);
    end
    bitIo(1'b1, ack);
  endtask

  // last = 1 answers with a not-acknowledge, ending the read
  task automatic getByte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, r);
      b[i] = r;
    end
    bitIo(last, r);
  endtask

  task automatic stop();
    sdaDrv = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(5);
    sdaDrv = 1'b1;
    tick(10);
  endtask
endmodule

// ===== tb/video_comb_filter_test.sv
// self-checking bench for the comb filter: video latency and register port
`timescale 1ns/100ps
module video_comb_filter_test;
  import comb_filter_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [7:0] compositeIn = 8'h00;
  logic [7:0] chromaIn = 8'h80;
  yc_t ycOut;
  logic scl;
  logic sdaLine;
  logic sdaOut;
  logic sdaOe;
  logic ack;
  logic [7:0] rd;
  logic [7:0] k;
  int bad_count = 0;
  int comparisons = 0;

  always #12.5 sys_clk = ~sys_clk;

  video_comb_filter u_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .compositeIn(compositeIn),
    .chromaIn(chromaIn),
    .ycOut(ycOut),
    .sclIn(scl),
    .sdaIn(sdaLine),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe)
  );

  i2c_master_model u_master (
    .sys_clk(sys_clk),
    .sdaOe(sdaOe),
    .scl(scl),
    .sdaLine(sdaLine)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic i2cWrite(input logic [7:0] seq[$]);
    logic a;
    u_master.start();
    foreach (seq[i]) begin
      u_master.sendByte(seq[i], a);
      chk("write ack", 16'h0000, {15'h0000, a});
    end
    u_master.stop();
  endtask

  // reads one byte from the subaddress left by the last write
  task automatic i2cRead(output logic [7:0] v);
    logic a;
    u_master.start();
    u_master.sendByte(8'hB3, a);
    chk("read address ack", 16'h0000, {15'h0000, a});
    u_master.getByte(1'b1, v);
    u_master.stop();
  endtask

  // blocks as long as the band-pass span put the full swing on chroma, luma stays flat
  task automatic ycRun(input int half);
    for (int i = 0; i < 48; i++) begin
      if (i >= 21 + 2 * half) begin
        k = (((i - 21) / half) % 2) ? 8'h40 : 8'hC0;
        chk("yc chroma", {8'h40, k}, ycOut);
      end
      chromaIn = ((i / half) % 2) ? 8'h40 : 8'hC0;
      cyc(1);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    cyc(3);
    chk("reset video", 16'h0000, ycOut);
    chk("reset sda drive", 16'h0000, {15'h0000, sdaOe});
    rst = 1'b0;
    // flat composite, no colour: band-pass sees nothing, low-pass passes the level
    compositeIn = 8'h40;
    chromaIn = 8'h80;
    cyc(40);
    compositeIn = 8'h60;
    // adder_tap_select reach at most four samples either side of the centre
    cyc(16);
    chk("filter before step", 16'h4080, ycOut);
    cyc(10);
    chk("filter after step", 16'h6080, ycOut);
    u_master.start();
    u_master.sendByte(8'hA2, ack);
    chk("foreign address", 16'h0001, {15'h0000, ack});
    u_master.stop();
    // combing stays off: bypass, then a stray byte past the control byte
    i2cWrite('{8'hB2, 8'h00, 8'h80, 8'h55});
    i2cRead(rd);
    chk("read after burst", 16'h0000, {8'h00, rd});
    i2cWrite('{8'hB2, 8'h00});
    i2cRead(rd);
    chk("control readback", 16'h0080, {8'h00, rd});
    chk("sda out level", 16'h0000, {15'h0000, sdaOut});
    // new control reaches the pipe at the next line wrap
    cyc(1800);
    for (int i = 0; i < 40; i++) begin
      if (i >= 3) begin
        k = 8'(i - 3);
        chk("bypass stream", {8'h10 + k, 8'hF0 - k}, ycOut);
      end
      compositeIn = 8'h10 + 8'(i);
      chromaIn = 8'hF0 - 8'(i);
      cyc(1);
    end
    // with the enable low every stage holds, the output included
    clkEn = 1'b0;
    compositeIn = 8'h00;
    cyc(5);
    chk("frozen output", 16'h35CB, ycOut);
    clkEn = 1'b1;
    compositeIn = 8'h40;
    i2cWrite('{8'hB2, 8'h00, 8'h40});
    cyc(1800);
    ycRun(3);
    i2cWrite('{8'hB2, 8'h00, 8'h44});
    cyc(1800);
    ycRun(4);
    wrap_up();
  end

  initial begin
    cyc(20000);
    bad_count++;
    $display("[ERR] watchdog expected done seen timeout");
    wrap_up();
  end
endmodule
